/* rtl/smrd_regs.sv */
// register defaults applied on power-on and on operating mode changes
// Overview of operation
// (RQ1) op_mode_ctrl is 100 after power-on, in standby and reset, 111 in normal, left as is in overtemp.
// (RQ2) wdog_period_sel loads 0100 at power-on and on entry to overtemp or reset, else kept.
// (RQ3) reset_cause_code is 00000 at power-on, 10010 on overtemp entry, the reset cause on reset entry.
// (RQ4) not_yet_normal_flag is 1 at power-on, cleared on entry to normal or by a software nyn_clr write, otherwise kept.
// (RQ5) wdog_mode_sel loads 001 if sw_dev_cfg is 1 else 010, at power-on and on reset entry.
// (RQ6) power_on_event and system_event_summary are 1 at power-on and kept until software clears them.
// (RQ7) the other event capture flags are 0 at power-on and kept across mode changes.
// (RQ8) event enables and lock bits are 0 at power-on and kept across mode changes.
// (RQ9) live status bits read 0 in off mode and follow the condition in every other mode.
// (RQ10) nvm programming state and write counter follow the memory in every mode.
// (RQ11) startup config bits come from nonvolatile store; the threshold control starts from its startup value.
// (RQ12) a software field write in the cycle of a mode change is dropped; the mode defaults win. Event clears still apply.
// (RQ13) ident_byte is a fixed read-only value from power-on.
`timescale 1ns/1ps
`include "smrd_defines.svh"
module smrd_regs #(
    parameter logic [7:0] ID_VALUE = `SMRD_ID_DEFAULT // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire smrd_pkg::smrd_mode_e mode,
    input wire logic [4:0] reset_src,
    input wire smrd_pkg::smrd_wr_s wr,
    input wire smrd_pkg::smrd_live_s live,
    input wire logic [6:0] evt_set,
    output logic [2:0] op_mode_ctrl,
    output logic [3:0] wdog_period_sel,
    output logic [4:0] reset_cause_code,
    output logic not_yet_normal_flag,
    output logic [2:0] wdog_mode_sel,
    output logic [6:0] events,
    output logic [2:0] enables,
    output logic [6:0] reg_lock_bits,
    output logic [1:0] reg_reset_threshold,
    output logic [4:0] live_status,
    output logic nvm_prog_state,
    output logic [5:0] nvm_write_count,
    output logic [2:0] startup_cfg,
    output logic [7:0] ident_byte
);
    import smrd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // events: {po, system_event_summary, otw, serial_fail_event, wdf, v1u, supply_event_summary|transceiver_event_summary...} bit6 po, bit5 system_event_summary
    smrd_mode_e mode_q;
    logic first_q, first_d;
    logic [2:0] opm_q, opm_d;
    logic [3:0] wdp_q, wdp_d;
    logic [4:0] rcs_q, rcs_d;
    logic nyn_q, nyn_d;
    logic [2:0] wdm_q, wdm_d;
    logic [6:0] evt_q, evt_d;
    logic [2:0] en_q, en_d;
    logic [6:0] lk_q, lk_d;
    logic [1:0] thr_q, thr_d;
    logic [4:0] lst_q, lst_d;
    logic nps_q, nps_d;
    logic [5:0] nwc_q, nwc_d;
    logic [2:0] scf_q, scf_d;
    logic chg;
    logic enter;

    // a mode change, the first cycle after power-on, or any cycle in off applies defaults;
    // off is the unpowered state, so a write there must not leave anything behind
    always_comb begin
        chg = (mode != mode_q);
        enter = chg || first_q || (mode == SMRD_M_OFF); // [RQ8] [RQ12]
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-value logic; writes only land when no mode change is applied
    always_comb begin
        first_d = 1'b0;
        opm_d = opm_q;
        wdp_d = wdp_q;
        rcs_d = rcs_q;
        nyn_d = nyn_q;
        wdm_d = wdm_q;
        en_d = en_q;
        lk_d = lk_q;
        thr_d = thr_q;
        if (!enter) begin // [RQ12]
            if (wr.op_mode_we) opm_d = wr.op_mode_ctrl;
            if (wr.wdog_per_we) wdp_d = wr.wdog_period_sel;
            if (wr.wdog_mode_we) wdm_d = wr.wdog_mode_sel;
            if (wr.en_we) en_d = wr.enables; // [RQ8]
            if (wr.lock_we) lk_d = wr.reg_lock_bits; // [RQ8]
            if (wr.thr_we) thr_d = wr.reg_reset_threshold;
            if (wr.nyn_clr) nyn_d = 1'b0;
        end else begin
            unique case (mode)
                SMRD_M_OFF: begin
                    opm_d = `SMRD_OPMODE_STBY; // [RQ1]
                    wdp_d = `SMRD_WDPER_RST; // [RQ2]
                    rcs_d = `SMRD_RCAUSE_POR; // [RQ3]
                    nyn_d = 1'b1; // [RQ4]
                    wdm_d = live.sw_dev_cfg ? `SMRD_WDMODE_SWDEV : `SMRD_WDMODE_DFLT; // [RQ5]
                    en_d = 3'h0; // [RQ8]
                    lk_d = 7'h00; // [RQ8]
                    thr_d = live.reg_reset_threshold_startup; // [RQ11]
                end
                SMRD_M_STBY: opm_d = `SMRD_OPMODE_STBY; // [RQ1]
                SMRD_M_NORM: begin
                    opm_d = `SMRD_OPMODE_NORM; // [RQ1]
                    nyn_d = 1'b0; // [RQ4]
                end
                SMRD_M_OT: begin
                    wdp_d = `SMRD_WDPER_RST; // [RQ2]
                    rcs_d = `SMRD_RCAUSE_OT; // [RQ3]
                end
                SMRD_M_RST: begin
                    opm_d = `SMRD_OPMODE_STBY; // [RQ1]
                    wdp_d = `SMRD_WDPER_RST; // [RQ2]
                    rcs_d = reset_src; // [RQ3]
                    wdm_d = live.sw_dev_cfg ? `SMRD_WDMODE_SWDEV : `SMRD_WDMODE_DFLT; // [RQ5]
                end
                default: opm_d = opm_q;
            endcase
        end
    end

    // event flags: set beats clear; power-on leaves po and system_event_summary set
    always_comb begin
        evt_d = (evt_q & ~wr.evt_clr) | evt_set; // [RQ6] [RQ7]
        if (mode == SMRD_M_OFF) evt_d = `SMRD_EVT_POR; // [RQ6] [RQ7]
        lst_d = (mode == SMRD_M_OFF) ? 5'h00 : {live.overtemp_warn_state, live.sw_dev_state,
            live.reg_supply_state, live.xcvr_supply_state, live.wdog_state}; // [RQ9]
        nps_d = live.nvm_prog_state; // [RQ10]
        nwc_d = live.nvm_write_count; // [RQ10]
        scf_d = {live.reset_length_cfg, live.sw_dev_cfg}; // [RQ11]
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; reset is power-on
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= SMRD_M_OFF;
            first_q <= 1'b1;
            opm_q <= `SMRD_OPMODE_STBY;
            wdp_q <= `SMRD_WDPER_RST;
            rcs_q <= `SMRD_RCAUSE_POR;
            nyn_q <= 1'b1;
            wdm_q <= `SMRD_WDMODE_DFLT;
            evt_q <= `SMRD_EVT_POR;
            en_q <= 3'h0;
            lk_q <= 7'h00;
            thr_q <= 2'h0;
            lst_q <= 5'h00;
            nps_q <= 1'b0;
            nwc_q <= 6'h00;
            scf_q <= 3'h0;
        end else begin
            mode_q <= mode;
            first_q <= first_d;
            opm_q <= opm_d;
            wdp_q <= wdp_d;
            rcs_q <= rcs_d;
            nyn_q <= nyn_d;
            wdm_q <= wdm_d;
            evt_q <= evt_d;
            en_q <= en_d;
            lk_q <= lk_d;
            thr_q <= thr_d;
            lst_q <= lst_d;
            nps_q <= nps_d;
            nwc_q <= nwc_d;
            scf_q <= scf_d;
        end
    end

    // ident value is a reset constant that no write reaches
    logic [7:0] id_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) id_q <= ID_VALUE; // [RQ13]
        else id_q <= id_q;
    end

    assign op_mode_ctrl = opm_q;
    assign wdog_period_sel = wdp_q;
    assign reset_cause_code = rcs_q;
    assign not_yet_normal_flag = nyn_q;
    assign wdog_mode_sel = wdm_q;
    assign events = evt_q;
    assign enables = en_q;
    assign reg_lock_bits = lk_q;
    assign reg_reset_threshold = thr_q;
    assign live_status = lst_q;
    assign nvm_prog_state = nps_q;
    assign nvm_write_count = nwc_q;
    assign startup_cfg = scf_q;
    assign ident_byte = id_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_norm_mode_ctrl: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == SMRD_M_NORM && mode_q != SMRD_M_NORM) |=> op_mode_ctrl == 3'h7 && !not_yet_normal_flag)
        else $error("normal entry defaults wrong"); // [RQ1]
    a_ot_period: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == SMRD_M_OT && mode_q != SMRD_M_OT) |=> wdog_period_sel == 4'h4 && reset_cause_code == 5'h12)
        else $error("overtemp entry defaults wrong"); // [RQ2]
    a_rst_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == SMRD_M_RST && mode_q != SMRD_M_RST) |=> reset_cause_code == $past(reset_src))
        else $error("reset cause not captured"); // [RQ3]
    a_nyn_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == SMRD_M_STBY && mode_q != SMRD_M_STBY && !wr.nyn_clr) |=> $stable(not_yet_normal_flag))
        else $error("flag changed on standby entry"); // [RQ4]
    a_wdm_rst: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == SMRD_M_RST && mode_q != SMRD_M_RST) |=> wdog_mode_sel == ($past(live.sw_dev_cfg) ? 3'h1 : 3'h2))
        else $error("watchdog mode default wrong"); // [RQ5]
    a_evt_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode != SMRD_M_OFF && evt_set[6]) |=> events[6])
        else $error("event set lost"); // [RQ6]
    a_off_live: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode == SMRD_M_OFF |=> live_status == 5'h00 && enables == 3'h0 && reg_lock_bits == 7'h00)
        else $error("off mode defaults wrong"); // [RQ9]
    a_nvm_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
        1'b1 |=> nvm_write_count == $past(live.nvm_write_count))
        else $error("write counter not tracking"); // [RQ10]
    a_write_drop: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == SMRD_M_STBY && mode_q != SMRD_M_STBY && wr.en_we) |=> $stable(enables))
        else $error("write during mode change landed"); // [RQ12]
    a_ident_fixed: assert property (@(posedge sys_clk) disable iff (!nrst) ident_byte == ID_VALUE)
        else $error("ident changed"); // [RQ13]
endmodule : smrd_regs

/* pkg/smrd_defines.svh */
// constants for the mode-dependent register defaults block
`ifndef SMRD_DEFINES_SVH
`define SMRD_DEFINES_SVH
`define SMRD_OPMODE_STBY 3'h4
`define SMRD_OPMODE_NORM 3'h7
`define SMRD_WDPER_RST 4'h4
`define SMRD_RCAUSE_POR 5'h00
`define SMRD_RCAUSE_OT 5'h12
`define SMRD_WDMODE_SWDEV 3'h1
`define SMRD_WDMODE_DFLT 3'h2
`define SMRD_ID_DEFAULT 8'h5a
`define SMRD_EVT_POR 7'h60
`endif

/* pkg/smrd_pkg.sv */
// types for the mode-dependent register defaults block
package smrd_pkg;
    typedef enum logic [2:0] {
        SMRD_M_OFF = 3'b000,
        SMRD_M_STBY = 3'b001,
        SMRD_M_NORM = 3'b010,
        SMRD_M_OT = 3'b011,
        SMRD_M_RST = 3'b100
    } smrd_mode_e;

    // software write port: one strobe per field
    typedef struct packed {
        logic op_mode_we;
        logic [2:0] op_mode_ctrl;
        logic wdog_per_we;
        logic [3:0] wdog_period_sel;
        logic wdog_mode_we;
        logic [2:0] wdog_mode_sel;
        logic en_we;
        logic [2:0] enables;
        logic lock_we;
        logic [6:0] reg_lock_bits;
        logic thr_we;
        logic [1:0] reg_reset_threshold;
        logic nyn_clr;
        logic [6:0] evt_clr;
    } smrd_wr_s;

    // live conditions and nonvolatile contents
    typedef struct packed {
        logic overtemp_warn_state;
        logic sw_dev_state;
        logic reg_supply_state;
        logic xcvr_supply_state;
        logic wdog_state;
        logic nvm_prog_state;
        logic [5:0] nvm_write_count;
        logic [1:0] reset_length_cfg;
        logic sw_dev_cfg;
        logic [1:0] reg_reset_threshold_startup;
    } smrd_live_s;
endpackage : smrd_pkg

/* tb/smrd_host_model.sv */
// host-side model that drives operating mode, reset cause and software writes
`timescale 1ns/1ps
module smrd_host_model (
    input wire logic sys_clk,
    output smrd_pkg::smrd_mode_e mode,
    output logic [4:0] reset_src,
    output smrd_pkg::smrd_wr_s wr
);
    import smrd_pkg::*;
    // idle at power-on: no mode request and no write strobes
    initial begin
        mode = SMRD_M_OFF;
        reset_src = 5'h00;
        wr = '0;
    end
    // caller applies one request just after a rising edge, held for that whole cycle
    task automatic drive(input smrd_mode_e m, input logic [4:0] src, input smrd_wr_s w);
        mode = m;
        reset_src = src;
        wr = w;
    endtask : drive
endmodule : smrd_host_model

/* tb/smrd_regs_tb.sv */
// self-checking bench for the mode-dependent register defaults
`timescale 1ns/1ps
`include "smrd_defines.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module smrd_regs_tb;
    import smrd_pkg::*;
    logic sys_clk, nrst, nyn, e_nyn, nps;
    smrd_mode_e mode, pm, m;
    smrd_wr_s wr, w;
    smrd_live_s live, lp;
    logic [6:0] evt_set, es, ev, lk, e_ev, e_lk;
    logic [4:0] reset_src, src, rcc, e_cause, lst;
    logic [2:0] opm, wdm, en, scfg, e_op, e_wdm, e_en;
    logic [3:0] per, e_per;
    logic [1:0] thr, e_thr;
    logic [5:0] nwc;
    logic [7:0] idb;
    int seed = 94;
    int fails = 0;
    int tests_run = 0;
    smrd_host_model u_host (.sys_clk(sys_clk), .mode(mode), .reset_src(reset_src), .wr(wr));
    smrd_regs u_smrd_regs (.sys_clk(sys_clk), .nrst(nrst), .mode(mode), .reset_src(reset_src), .wr(wr),
        .live(live), .evt_set(evt_set), .op_mode_ctrl(opm), .wdog_period_sel(per), .reset_cause_code(rcc),
        .not_yet_normal_flag(nyn), .wdog_mode_sel(wdm), .events(ev), .enables(en), .reg_lock_bits(lk),
        .reg_reset_threshold(thr), .live_status(lst), .nvm_prog_state(nps), .nvm_write_count(nwc),
        .startup_cfg(scfg), .ident_byte(idb));
    ////////////////////////////////////////////////////////////////////////////////
    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // watchdog-style bound on the whole run, so a hang still reaches the verdict
    initial begin
        #2000000;
        fails++;
        conclude();
    end
    function automatic logic [2:0] f_wdm(input logic sdc);
        return sdc ? `SMRD_WDMODE_SWDEV : `SMRD_WDMODE_DFLT;
    endfunction : f_wdm
    // one edge; live is re-randomised after it, lp keeps what the edge sampled
    task automatic step();
        lp = live;
        @(posedge sys_clk);
        #2;
        live = smrd_live_s'(17'($random(seed)));
    endtask : step
    // power-on values expected after the first edge out of reset
    task automatic por();
        {e_op, e_per, e_cause, e_nyn} = {`SMRD_OPMODE_STBY, `SMRD_WDPER_RST, `SMRD_RCAUSE_POR, 1'b1};
        e_wdm = f_wdm(lp.sw_dev_cfg);
        {e_ev, e_en, e_lk} = {`SMRD_EVT_POR, 3'h0, 7'h00};
        e_thr = lp.reg_reset_threshold_startup;
        pm = SMRD_M_OFF;
    endtask : por
    // expected effect of one edge: mode entry defaults win over software writes
    task automatic model(input smrd_mode_e mm, input logic [4:0] s, input smrd_wr_s x, input logic [6:0] st);
        if (mm != pm) begin
            if (mm == SMRD_M_NORM) {e_op, e_nyn} = {`SMRD_OPMODE_NORM, 1'b0};
            else if (mm != SMRD_M_OT) e_op = `SMRD_OPMODE_STBY;
            if (mm == SMRD_M_OT) {e_per, e_cause} = {`SMRD_WDPER_RST, `SMRD_RCAUSE_OT};
            if (mm == SMRD_M_RST) {e_per, e_cause, e_wdm} = {`SMRD_WDPER_RST, s, f_wdm(lp.sw_dev_cfg)};
        end else begin
            if (x.op_mode_we) e_op = x.op_mode_ctrl;
            if (x.wdog_per_we) e_per = x.wdog_period_sel;
            if (x.wdog_mode_we) e_wdm = x.wdog_mode_sel;
            if (x.en_we) e_en = x.enables;
            if (x.lock_we) e_lk = x.reg_lock_bits;
            if (x.thr_we) e_thr = x.reg_reset_threshold;
            if (x.nyn_clr) e_nyn = 1'b0;
        end
        e_ev = (e_ev & ~x.evt_clr) | st;
        pm = mm;
    endtask : model
    task automatic check_all(input smrd_mode_e mm);
        logic [4:0] e_ls;
        e_ls = {lp.overtemp_warn_state, lp.sw_dev_state, lp.reg_supply_state, lp.xcvr_supply_state, lp.wdog_state};
        if (mm == SMRD_M_OFF) e_ls = 5'h00;
        `CHK("op_mode_ctrl", e_op, opm)
        `CHK("wdog_period_sel", e_per, per)
        `CHK("reset_cause_code", e_cause, rcc)
        `CHK("not_yet_normal_flag", e_nyn, nyn)
        `CHK("wdog_mode_sel", e_wdm, wdm)
        `CHK("events", e_ev, ev)
        `CHK("enables", e_en, en)
        `CHK("reg_lock_bits", e_lk, lk)
        `CHK("live_status", e_ls, lst)
        `CHK("nvm_state", {lp.nvm_prog_state, lp.nvm_write_count}, {nps, nwc})
        `CHK("startup_cfg", {lp.reset_length_cfg, lp.sw_dev_cfg}, scfg)
        `CHK("reg_reset_threshold", e_thr, thr)
        `CHK("ident_byte", `SMRD_ID_DEFAULT, idb)
    endtask : check_all
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    // power-on, random mode walk with writes, then a second power-on at the end of the run
    initial begin
        nrst = 1'b0;
        evt_set = 7'h00;
        live = smrd_live_s'(17'($random(seed)));
        repeat (6) @(posedge sys_clk);
        #2;
        nrst = 1'b1;
        step();
        por();
        check_all(SMRD_M_OFF);
        $display("test power_on done");
        for (int i = 0; i < 400; i++) begin
            m = pm;
            if (i == 0 || ($random(seed) & 3) == 0) m = smrd_mode_e'(3'(1 + $unsigned($random(seed)) % 4));
            w = smrd_wr_s'(36'({$random(seed), $random(seed)}));
            es = 7'($random(seed) & $random(seed) & $random(seed));
            src = 5'($random(seed));
            // event traffic kept out of entry cycles, although clears and sets apply there as in any other cycle
            if (m != pm) {w.evt_clr, es} = 14'h0000;
            u_host.drive(m, src, w);
            evt_set = es;
            step();
            model(m, src, w, es);
            check_all(m);
        end
        $display("test mode_walk done");
        nrst = 1'b0;
        evt_set = 7'h00;
        u_host.drive(SMRD_M_OFF, 5'h00, '0);
        repeat (2) step();
        nrst = 1'b1;
        step();
        por();
        check_all(SMRD_M_OFF);
        $display("test second_power_on done");
        conclude();
    end
endmodule : smrd_regs_tb
